// ---- hdl/psb_top.sv ----
// eight-channel pressure setpoint bank: configuration, source limits, outputs
`default_nettype none
module psb_top
  import psb_pkg::*;
#(
  parameter int NG         = NUM_GAUGE,
  parameter int PW         = PRESS_W,
  parameter int DW         = DLY_W,
  parameter int STEP_CYCLES = DLY_STEP_CYCLES
) (
  input  wire logic             core_clk,
  input  wire logic             rst,
  input  wire logic [NG*PW-1:0] gauge_pressure,
  input  wire logic             cfg_we,
  input  wire logic [2:0]       cfg_ch,
  input  wire psb_field_t       cfg_field,
  input  wire logic [PW-1:0]    cfg_data,
  output logic                  cfg_refused,
  output logic [NUM_CH-1:0]     sp_out_n,
  output logic [NUM_CH-1:0]     sp_status,
  output logic [NUM_CH-1:0]     ind_show,
  output logic [NUM_CH-1:0]     ch_err,
  output logic [NG-1:0]         gauge_avail
);
  localparam int GW = $clog2(NG + 1);
  localparam int CW = $clog2(NUM_CH + 1);
  localparam int TW = $clog2(STEP_CYCLES + 1);

  // refuse widths the source index or delay fields cannot fit into
  if (NG < 1 || PW < GW || PW < DW || PW < 2 || STEP_CYCLES < 1) begin : g_bad_params
    $error("psb_top: unsupported parameter set");
  end

  ////////////////////////////////////////////////////////////////////////////
  // delay step tick, one pulse every tenth of a second

  logic [TW-1:0] tick_cnt_reg, tick_cnt_next;
  logic          tick_reg, tick_next;

  always_comb begin
    tick_next     = 1'b0;
    tick_cnt_next = tick_cnt_reg + 1'b1;
    if (tick_cnt_reg == TW'(STEP_CYCLES - 1)) begin
      tick_cnt_next = '0;
      tick_next     = 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      tick_cnt_reg <= '0;
      tick_reg     <= 1'b0;
    end else begin
      tick_cnt_reg <= tick_cnt_next;
      tick_reg     <= tick_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // per-channel configuration

  logic [GW-1:0] src_reg     [NUM_CH];
  logic [GW-1:0] src_next    [NUM_CH];
  logic [PW-1:0] on_thr_reg  [NUM_CH];
  logic [PW-1:0] on_thr_next [NUM_CH];
  logic [PW-1:0] off_thr_reg [NUM_CH];
  logic [PW-1:0] off_thr_next[NUM_CH];
  logic [DW-1:0] on_dly_reg  [NUM_CH];
  logic [DW-1:0] on_dly_next [NUM_CH];
  logic [DW-1:0] off_dly_reg [NUM_CH];
  logic [DW-1:0] off_dly_next[NUM_CH];
  psb_mode_t     mode_reg    [NUM_CH];
  psb_mode_t     mode_next   [NUM_CH];
  logic          refused_next;
  logic [CW-1:0] gauge_cnt   [2**GW];
  logic          gauge_ok;

  // how many channels point at each gauge; index 0 is "no source"
  always_comb begin
    for (int g = 0; g < 2**GW; g++) begin
      gauge_cnt[g] = '0;
    end
    for (int c = 0; c < NUM_CH; c++) begin
      gauge_cnt[src_reg[c]] = gauge_cnt[src_reg[c]] + 1'b1;
    end
  end

  // reselecting the channel's own gauge never counts against the limit
  always_comb begin
    gauge_ok = (cfg_data <= PW'(NG))
            && ((src_reg[cfg_ch] == cfg_data[GW-1:0])
            || (gauge_cnt[cfg_data[GW-1:0]] < CW'(MAX_PER_GAUGE)));
  end

  always_comb begin
    for (int c = 0; c < NUM_CH; c++) begin
      src_next[c]     = src_reg[c];
      on_thr_next[c]  = on_thr_reg[c];
      off_thr_next[c] = off_thr_reg[c];
      on_dly_next[c]  = on_dly_reg[c];
      off_dly_next[c] = off_dly_reg[c];
      mode_next[c]    = mode_reg[c];
    end
    refused_next = 1'b0;
    if (cfg_we) begin
      case (cfg_field)
        FLD_SOURCE: begin
          if (cfg_data == PW'(SRC_NONE)) begin
            src_next[cfg_ch]     = '0;
            on_thr_next[cfg_ch]  = '0;
            off_thr_next[cfg_ch] = '0;
            on_dly_next[cfg_ch]  = '0;
            off_dly_next[cfg_ch] = '0;
            mode_next[cfg_ch]    = MODE_OFF;
          end else if (gauge_ok) begin
            src_next[cfg_ch] = cfg_data[GW-1:0];
          end else begin
            refused_next = 1'b1;
          end
        end
        FLD_ON_THR: begin
          on_thr_next[cfg_ch] = cfg_data;
        end
        FLD_OFF_THR: begin
          off_thr_next[cfg_ch] = cfg_data;
        end
        FLD_ON_DLY: begin
          on_dly_next[cfg_ch] = cfg_data[DW-1:0];
          refused_next        = cfg_data > PW'({DW{1'b1}});
          if (refused_next) begin
            on_dly_next[cfg_ch] = on_dly_reg[cfg_ch];
          end
        end
        FLD_OFF_DLY: begin
          off_dly_next[cfg_ch] = cfg_data[DW-1:0];
          refused_next         = cfg_data > PW'({DW{1'b1}});
          if (refused_next) begin
            off_dly_next[cfg_ch] = off_dly_reg[cfg_ch];
          end
        end
        FLD_MODE: begin
          // only the mode changes; thresholds and delays stay stored
          if (cfg_data == PW'(MODE_AUTO)) begin
            mode_next[cfg_ch] = MODE_AUTO;
          end else if (cfg_data == PW'(MODE_ON)) begin
            mode_next[cfg_ch] = MODE_ON;
          end else if (cfg_data == PW'(MODE_OFF)) begin
            mode_next[cfg_ch] = MODE_OFF;
          end else begin
            refused_next = 1'b1;
          end
        end
        default: begin
          refused_next = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      for (int c = 0; c < NUM_CH; c++) begin
        src_reg[c]     <= '0;
        on_thr_reg[c]  <= '0;
        off_thr_reg[c] <= '0;
        on_dly_reg[c]  <= '0;
        off_dly_reg[c] <= '0;
        mode_reg[c]    <= MODE_AUTO;
      end
      cfg_refused <= 1'b0;
    end else begin
      for (int c = 0; c < NUM_CH; c++) begin
        src_reg[c]     <= src_next[c];
        on_thr_reg[c]  <= on_thr_next[c];
        off_thr_reg[c] <= off_thr_next[c];
        on_dly_reg[c]  <= on_dly_next[c];
        off_dly_reg[c] <= off_dly_next[c];
        mode_reg[c]    <= mode_next[c];
      end
      cfg_refused <= refused_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // gauge availability for the source list

  logic [NG-1:0] avail_next;

  always_comb begin
    for (int g = 0; g < NG; g++) begin
      avail_next[g] = gauge_cnt[g + 1] < CW'(MAX_PER_GAUGE);
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      gauge_avail <= '1;
    end else begin
      gauge_avail <= avail_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // channels and their outputs

  logic [NUM_CH-1:0] active;
  logic [NUM_CH-1:0] err_now;
  logic [NUM_CH-1:0] out_n_next, status_next, show_next;

  for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
    logic [PW-1:0] press;

    // gauge n lives at slice n-1; a channel with no source reads zero
    assign press = (src_reg[c] == '0) ? '0
                 : gauge_pressure[(32'(src_reg[c]) - 1) * PW +: PW];
    // an error shows only while the comparison would be in charge
    assign err_now[c] = (mode_reg[c] == MODE_AUTO)
                     && (on_thr_reg[c] >= off_thr_reg[c]);

    psb_channel #(
      .PW (PW),
      .DW (DW)
    ) u_ch (
      .core_clk (core_clk),
      .rst      (rst),
      .tick     (tick_reg),
      .pressure (press),
      .on_thr   (on_thr_reg[c]),
      .off_thr  (off_thr_reg[c]),
      .on_dly   (on_dly_reg[c]),
      .off_dly  (off_dly_reg[c]),
      .mode     (mode_reg[c]),
      .thr_err  (err_now[c]),
      .active   (active[c])
    );

    // sp_out_n and sp_status switch on the same edge; ind_show can also switch on its own when mode_reg or src_reg changes
    assign out_n_next[c]  = !active[c];
    assign status_next[c] = active[c];
    assign show_next[c]   = active[c] && (mode_reg[c] == MODE_AUTO)
                         && (src_reg[c] != '0);
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      sp_out_n  <= '1;
      sp_status <= '0;
      ind_show  <= '0;
      ch_err    <= '0;
    end else begin
      sp_out_n  <= out_n_next;
      sp_status <= status_next;
      ind_show  <= show_next;
      ch_err    <= err_now;
    end
  end
endmodule
`default_nettype wire

// ---- hdl/psb_pkg.sv ----
// constants and types shared by the pressure setpoint bank
`default_nettype none
package psb_pkg;
  localparam int NUM_CH          = 8;
  localparam int NUM_GAUGE       = 12;
  localparam int PRESS_W         = 16;
  localparam int DLY_W           = 8;
  localparam int MAX_PER_GAUGE   = 2;
  localparam int CLK_PERIOD_NS   = 8;
  localparam int DLY_STEP_NS     = 100_000_000;
  localparam int DLY_STEP_CYCLES = DLY_STEP_NS / CLK_PERIOD_NS;
  localparam int SRC_NONE        = 0;

  typedef enum logic [2:0] {
    FLD_SOURCE  = 3'h0,
    FLD_ON_THR  = 3'h1,
    FLD_OFF_THR = 3'h2,
    FLD_ON_DLY  = 3'h3,
    FLD_OFF_DLY = 3'h4,
    FLD_MODE    = 3'h5
  } psb_field_t;

  typedef enum logic [1:0] {
    MODE_AUTO = 2'h0,
    MODE_ON   = 2'h1,
    MODE_OFF  = 2'h2
  } psb_mode_t;

  typedef enum logic [3:0] {
    ST_OFF      = 4'h1,
    ST_WAIT_ON  = 4'h2,
    ST_ON       = 4'h4,
    ST_WAIT_OFF = 4'h8
  } psb_state_t;
endpackage
`default_nettype wire

// ---- hdl/psb_channel.sv ----
// one setpoint channel: compare, hysteresis, on/off delays, override modes
`default_nettype none
module psb_channel
  import psb_pkg::*;
#(
  parameter int PW = PRESS_W,
  parameter int DW = DLY_W
) (
  input  wire logic          core_clk,
  input  wire logic          rst,
  input  wire logic          tick,
  input  wire logic [PW-1:0] pressure,
  input  wire logic [PW-1:0] on_thr,
  input  wire logic [PW-1:0] off_thr,
  input  wire logic [DW-1:0] on_dly,
  input  wire logic [DW-1:0] off_dly,
  input  wire psb_mode_t     mode,
  input  wire logic          thr_err,
  output logic               active
);
  psb_state_t    state_reg, state_next;
  logic [DW-1:0] cnt_reg, cnt_next;
  logic          on_cond, off_cond;

  assign on_cond  = pressure < on_thr;
  assign off_cond = pressure > off_thr;
  assign active   = (state_reg == ST_ON) || (state_reg == ST_WAIT_OFF);

  always_comb begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    if (mode == MODE_ON) begin
      state_next = ST_ON;
      cnt_next   = '0;
    end else if (mode != MODE_AUTO || thr_err) begin
      // a bad threshold pair keeps the output released rather than guessing
      state_next = ST_OFF;
      cnt_next   = '0;
    end else begin
      case (state_reg)
        ST_OFF: begin
          if (on_cond) begin
            state_next = ST_WAIT_ON;
          end
        end
        ST_WAIT_ON: begin
          if (!on_cond) begin
            state_next = ST_OFF;
            cnt_next   = '0;
          end else if (cnt_reg >= on_dly) begin
            state_next = ST_ON;
            cnt_next   = '0;
          end else if (tick) begin
            cnt_next = cnt_reg + 1'b1;
          end
        end
        ST_ON: begin
          if (off_cond) begin
            state_next = ST_WAIT_OFF;
          end
        end
        ST_WAIT_OFF: begin
          if (!off_cond) begin
            state_next = ST_ON;
            cnt_next   = '0;
          end else if (cnt_reg >= off_dly) begin
            state_next = ST_OFF;
            cnt_next   = '0;
          end else if (tick) begin
            cnt_next = cnt_reg + 1'b1;
          end
        end
        default: begin
          state_next = ST_OFF;
          cnt_next   = '0;
        end
      endcase
      // between the thresholds ST_OFF and ST_ON are held, while a wait state falls back to the state it left
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      state_reg <= ST_OFF;
      cnt_reg   <= '0;
    end else begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
    end
  end
endmodule
`default_nettype wire

// ---- test/psb_top_properties.sv ----
// concurrent checks on the setpoint bank ports
`default_nettype none
module psb_props
  import psb_pkg::*;
#(
  parameter int NG = NUM_GAUGE,
  parameter int PW = PRESS_W
) (
  input wire logic              core_clk,
  input wire logic              rst,
  input wire logic [NG*PW-1:0]  gauge_pressure,
  input wire logic              cfg_we,
  input wire logic [2:0]        cfg_ch,
  input wire psb_field_t        cfg_field,
  input wire logic [PW-1:0]     cfg_data,
  input wire logic              cfg_refused,
  input wire logic [NUM_CH-1:0] sp_out_n,
  input wire logic [NUM_CH-1:0] sp_status,
  input wire logic [NUM_CH-1:0] ind_show,
  input wire logic [NUM_CH-1:0] ch_err,
  input wire logic [NG-1:0]     gauge_avail
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking dcb @(posedge core_clk);
  endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////////////
  a_out_status_pair: assert property (sp_out_n == ~sp_status)
    else $error("output line and status disagree");
  a_ind_needs_active: assert property ((ind_show & ~sp_status) == 8'h00)
    else $error("indicator shown for inactive channel");
  a_src_range_refused: assert property (
    cfg_we && cfg_field == FLD_SOURCE && cfg_data > 16'(NG) |=> cfg_refused)
    else $error("out of range source accepted");
  a_mode_code_refused: assert property (
    cfg_we && cfg_field == FLD_MODE && cfg_data > 16'h0002 |=> cfg_refused)
    else $error("bad mode code accepted");
  a_refuse_has_cause: assert property (cfg_refused |-> $past(cfg_we))
    else $error("refusal without a write");
  // 4 edges covers write, mode, state and output registers
  a_forced_on_drive: assert property (
    $past(cfg_we && cfg_field == FLD_MODE && cfg_data == 16'h0001, 4)
    |-> !sp_out_n[$past(cfg_ch, 4)] && !ind_show[$past(cfg_ch, 4)])
    else $error("forced on not driven or shown");
  a_forced_off_drive: assert property (
    $past(cfg_we && cfg_field == FLD_MODE && cfg_data == 16'h0002, 4)
    |-> sp_out_n[$past(cfg_ch, 4)])
    else $error("forced off not released");
  a_err_inactive: assert property (
    (ch_err & $past(ch_err, 1) & $past(ch_err, 2) & $past(ch_err, 3) & sp_status) == 8'h00)
    else $error("channel active while in error");
  a_reset_quiet: assert property (disable iff (1'b0)
    rst |=> sp_out_n == 8'hff && sp_status == 8'h00 && ind_show == 8'h00 && !cfg_refused)
    else $error("outputs not idle after reset");
endmodule
bind psb_top psb_props #(.NG(NG), .PW(PW)) i_props (.core_clk(core_clk), .rst(rst),
  .gauge_pressure(gauge_pressure), .cfg_we(cfg_we), .cfg_ch(cfg_ch), .cfg_field(cfg_field),
  .cfg_data(cfg_data), .cfg_refused(cfg_refused), .sp_out_n(sp_out_n), .sp_status(sp_status),
  .ind_show(ind_show), .ch_err(ch_err), .gauge_avail(gauge_avail));
`default_nettype wire

// ---- test/psb_load.sv ----
// load model: equipment energised by the setpoint output lines
`default_nettype none
module psb_load (
  input  wire logic      core_clk,
  input  wire logic [7:0] sp_out_n,
  output var logic [7:0]  energized
);
  timeunit 1ns;
  timeprecision 1ps;
  // relay input: one cycle of pickup lag, energised while the line is low
  always_ff @(posedge core_clk) begin
    energized <= ~sp_out_n;
  end
endmodule
`default_nettype wire

// ---- test/psb_top_test.sv ----
// self-checking bench for the setpoint bank
`default_nettype none
module psb_top_test
  import psb_pkg::*;
  ;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int SC = 10;
  logic                         core_clk = 1'b0;
  logic                         rst = 1'b1;
  logic [NUM_GAUGE*PRESS_W-1:0] gauge_pressure = '0;
  logic                         cfg_we = 1'b0;
  logic [2:0]                   cfg_ch = 3'h0;
  psb_field_t                   cfg_field = FLD_SOURCE;
  logic [PRESS_W-1:0]           cfg_data = 16'h0000;
  logic                         cfg_refused;
  logic [NUM_CH-1:0]            sp_out_n, sp_status, ind_show, ch_err, energized;
  logic [NUM_GAUGE-1:0]         gauge_avail;
  logic                         rf;
  int                           miscompares = 0;
  int                           samples_checked = 0;
  int                           n;
  always #4 core_clk = ~core_clk;
  ////////////////////////////////////////////////////////////////////
  psb_top #(.STEP_CYCLES(SC)) i_dut (.core_clk(core_clk), .rst(rst),
    .gauge_pressure(gauge_pressure), .cfg_we(cfg_we), .cfg_ch(cfg_ch), .cfg_field(cfg_field),
    .cfg_data(cfg_data), .cfg_refused(cfg_refused), .sp_out_n(sp_out_n),
    .sp_status(sp_status), .ind_show(ind_show), .ch_err(ch_err), .gauge_avail(gauge_avail));
  psb_load i_load (.core_clk(core_clk), .sp_out_n(sp_out_n), .energized(energized));
  ////////////////////////////////////////////////////////////////////
  task automatic stop_test();
    $display("counts: %0d miscompares, %0d samples checked", miscompares, samples_checked);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // one write, then the refusal pulse is sampled after the taking edge
  task automatic wr(input int ch, input psb_field_t f, input logic [15:0] d);
    @(posedge core_clk);
    cfg_we <= 1'b1;
    cfg_ch <= 3'(ch);
    cfg_field <= f;
    cfg_data <= d;
    @(posedge core_clk);
    cfg_we <= 1'b0;
    #1;
    rf = cfg_refused;
  endtask
  task automatic setp(input logic [15:0] v);
    @(posedge core_clk);
    gauge_pressure[15:0] <= v;
  endtask
  task automatic waitst(input int ch, input logic v, input int lim);
    n = 0;
    while (sp_status[ch] !== v) begin
      @(posedge core_clk);
      #1;
      n++;
      if (n > lim) begin
        miscompares++;
        stop_test();
      end
    end
  endtask
  task automatic settle(input int c);
    repeat (c) @(posedge core_clk);
    #1;
  endtask
  ////////////////////////////////////////////////////////////////////
  initial begin
    gauge_pressure[15:0] = 16'h0096;
    repeat (5) @(posedge core_clk);
    rst <= 1'b0;
    settle(2);
    cmp(16'(sp_out_n), 16'h00ff);
    cmp(16'(gauge_avail), 16'h0fff);
    cmp(16'(ch_err), 16'h00ff);
    wr(0, FLD_SOURCE, 16'h0001);
    wr(0, FLD_ON_THR, 16'h0064);
    wr(0, FLD_OFF_THR, 16'h00c8);
    settle(10);
    cmp(16'(ch_err), 16'h00fe);
    cmp(16'(sp_out_n), 16'h00ff);
    setp(16'h0032);
    waitst(0, 1'b1, 8);
    cmp(16'(sp_out_n), 16'h00fe);
    cmp(16'(ind_show), 16'h0001);
    setp(16'h0096);
    settle(10);
    cmp(16'(sp_out_n), 16'h00fe);
    cmp(16'(energized), 16'h0001);
    setp(16'h00fa);
    waitst(0, 1'b0, 8);
    cmp(16'(sp_out_n | ind_show), 16'h00ff);
    wr(0, FLD_ON_DLY, 16'h0003);
    wr(0, FLD_OFF_DLY, 16'h0002);
    setp(16'h0032);
    settle(15);
    setp(16'h0096); // condition lost before three ticks
    settle(50);
    cmp(16'(sp_status), 16'h0000);
    setp(16'h0032);
    waitst(0, 1'b1, 60);
    // free-running tick: d steps land between d-1 and d tick periods
    cmp(16'(n >= 2 * SC + 4 && n <= 3 * SC + 3), 16'h0001);
    wr(0, FLD_ON_THR, 16'h00c8);
    waitst(0, 1'b0, 10);
    cmp(16'(ch_err[0]), 16'h0001);
    wr(0, FLD_OFF_THR, 16'h012c);
    settle(2);
    cmp(16'(ch_err[0]), 16'h0000);
    waitst(0, 1'b1, 60);
    wr(0, FLD_MODE, 16'h0002);
    settle(4);
    cmp(16'(sp_out_n[0]), 16'h0001);
    wr(0, FLD_MODE, 16'h0001);
    setp(16'h01f4);
    settle(4);
    cmp(16'(sp_status[0] | ind_show[0] << 1), 16'h0001);
    wr(0, FLD_MODE, 16'h0000);
    waitst(0, 1'b0, 60);
    cmp(16'(n >= SC + 4 && n <= 2 * SC + 3), 16'h0001);
    wr(1, FLD_SOURCE, 16'h0001);
    cmp(16'(rf), 16'h0000);
    wr(2, FLD_SOURCE, 16'h0001);
    cmp(16'(rf), 16'h0001);
    cmp(16'(gauge_avail[0]), 16'h0000);
    wr(2, FLD_SOURCE, 16'h000d);
    cmp(16'(rf), 16'h0001);
    wr(2, psb_field_t'(3'h6), 16'h0000);
    cmp(16'(rf), 16'h0001);
    wr(2, FLD_MODE, 16'h0003);
    cmp(16'(rf), 16'h0001);
    wr(1, FLD_SOURCE, 16'h0001);
    cmp(16'(rf), 16'h0000);
    wr(1, FLD_ON_THR, 16'h0064);
    wr(1, FLD_OFF_THR, 16'h00c8);
    setp(16'h0032);
    waitst(1, 1'b1, 8);
    wr(1, FLD_SOURCE, 16'h0000);
    waitst(1, 1'b0, 8);
    cmp(16'({gauge_avail[0], ch_err[1]}), 16'h0002);
    wr(1, FLD_SOURCE, 16'h0001);
    wr(1, FLD_MODE, 16'h0000);
    settle(4);
    cmp(16'({ch_err[1], sp_status[1]}), 16'h0002);
    stop_test();
  end
endmodule
`default_nettype wire
